// ### rtl/evm_regs.svh
// Register map, field positions, reset values and timing for the monitor.
`ifndef EVM_REGS_SVH
`define EVM_REGS_SVH

`define EVM_ADDR_START    8'hD8
`define EVM_ADDR_ENABLE   8'hEC
`define EVM_ADDR_RESULT   8'hEF
`define EVM_ADDR_DELTA    8'hF3
`define EVM_ADDR_FLAGS    8'hF8
`define EVM_ADDR_INTERVAL 8'hF9

`define EVM_BIT_SINGLE_GO 2
`define EVM_BIT_VCHG 3
`define EVM_BIT_VCHG_EN 3
`define EVM_DELTA_LSB 0
`define EVM_DELTA_W 3
`define EVM_VPER_LSB 4
`define EVM_VPER_W 2

`define EVM_RST_START    8'h00
`define EVM_RST_ENABLE   8'h00
`define EVM_RST_RESULT   8'h00
`define EVM_RST_DELTA    8'h00
`define EVM_RST_FLAGS    8'h00
`define EVM_RST_INTERVAL 8'h00
`define EVM_RDATA_NONE   8'h00

`define EVM_CLK_MHZ 125
`define EVM_BASE_TIME_US 1000
`define EVM_BASE_CYCLES (`EVM_BASE_TIME_US * `EVM_CLK_MHZ)

`endif

// ### rtl/evm_pkg.sv
// Types shared by the external voltage monitor files.
package evm_pkg;

  typedef enum logic [1:0] {
    EVM_PWR_FULL = 2'b00,
    EVM_PWR_BATTERY = 2'b01,
    EVM_PWR_SLEEP = 2'b10
  } evm_pwr_t;

  typedef enum logic [1:0] {
    EVM_ST_IDLE = 2'b00,
    EVM_ST_CONV = 2'b01,
    EVM_ST_EVAL = 2'b10
  } evm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } evm_sfr_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] data;
  } evm_conv_t;

endpackage

// ### rtl/evm_interval_timer.sv
// Background conversion interval timer.
`timescale 1ns/1ps
module evm_interval_timer #(
  parameter int BASE_CYCLES = 125000,
  parameter int CODE_W = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [CODE_W-1:0] i_code,
  output logic o_tick
);
  localparam int CNT_W = $clog2(BASE_CYCLES << ((1 << CODE_W) - 1)) + 1;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;

  // Each code step doubles the interval; code zero means stopped.
  always_comb begin
    limit = CNT_W'(BASE_CYCLES) << (i_code - CODE_W'(1));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_run || i_code == '0) begin
      count <= '0;
      o_tick <= 1'b0;
    end else if (count >= limit - CNT_W'(1)) begin
      count <= '0;
      o_tick <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule // evm_interval_timer

// ### rtl/evm_ctrl.sv
// External voltage ADC control: start logic, delta compare and registers.
`timescale 1ns/1ps
`include "evm_regs.svh"
module evm_ctrl #(
  parameter int BASE_CYCLES = `EVM_BASE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire evm_pkg::evm_sfr_req_t i_sfr,
  input wire evm_pkg::evm_pwr_t i_power_mode,
  input wire evm_pkg::evm_conv_t i_conv,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic o_conv_start,
  output logic o_adc_irq,
  output logic o_psm_irq
);

  evm_pkg::evm_state_t state;
  evm_pkg::evm_state_t next_state;

  logic [7:0] adc_start_control;
  logic [7:0] power_event_enable;
  logic [7:0] ext_voltage_result;
  logic [7:0] change_delta_config;
  logic [7:0] power_event_flags;
  logic [7:0] background_interval_config;

  logic [7:0] reference;
  logic [7:0] sample;
  logic from_single;
  logic bg_pending;
  logic bg_tick;
  logic bg_allowed;
  logic single_allowed;
  logic launch_single;
  logic launch_bg;
  logic big_change;
  logic single_done;
  logic change_hit;
  logic [`EVM_VPER_W-1:0] voltage_background_interval;
  logic [`EVM_DELTA_W-1:0] voltage_change_delta;

  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  function automatic logic sfr_write(input evm_pkg::evm_sfr_req_t req,
                                     input logic [7:0] addr);
    sfr_write = req.wr && (req.addr == addr);
  endfunction

  assign voltage_background_interval =
    background_interval_config[`EVM_VPER_LSB +: `EVM_VPER_W];
  assign voltage_change_delta =
    change_delta_config[`EVM_DELTA_LSB +: `EVM_DELTA_W];

  // Mode gating.
  // Full power permits both kinds of conversion.
  // Mode gating.
  // Battery operation never runs the background timer.
  // Mode gating.
  // Sleep has no processor, so a set start bit waits for wake-up.
  // The unused mode code 11 permits neither kind of conversion, so a
  // glitch on the mode bus can never start the converter.
  always_comb begin
    single_allowed = (i_power_mode == evm_pkg::EVM_PWR_FULL) ||
                     (i_power_mode == evm_pkg::EVM_PWR_BATTERY);
    bg_allowed = (i_power_mode == evm_pkg::EVM_PWR_FULL) ||
                 (i_power_mode == evm_pkg::EVM_PWR_SLEEP);
  end

  // Background off.
  // The interval field resets to zero, which stops the timer.
  // Interval timer.
  evm_interval_timer #(
    .BASE_CYCLES(BASE_CYCLES),
    .CODE_W(`EVM_VPER_W)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_run(bg_allowed),
    .i_code(voltage_background_interval),
    .o_tick(bg_tick)
  );

  // A tick that lands while a conversion runs is held, not dropped, so
  // a long single conversion cannot starve the background schedule.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bg_pending <= 1'b0;
    end else if (bg_tick) begin
      bg_pending <= 1'b1;
    end else if (launch_bg || !bg_allowed ||
                 voltage_background_interval == '0) begin
      bg_pending <= 1'b0;
    end
  end

  // Start request.
  // Single conversions take priority over a waiting background one.
  // Both launches need the idle state, so the converter never sees a
  // second start before it has answered the first.
  always_comb begin
    launch_single = (state == evm_pkg::EVM_ST_IDLE) && single_allowed &&
                    adc_start_control[`EVM_BIT_SINGLE_GO];
    launch_bg = (state == evm_pkg::EVM_ST_IDLE) && !launch_single &&
                bg_pending && bg_allowed;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      evm_pkg::EVM_ST_IDLE: begin
        if (launch_single || launch_bg) begin
          next_state = evm_pkg::EVM_ST_CONV;
        end
      end
      evm_pkg::EVM_ST_CONV: begin
        if (i_conv.done) begin
          next_state = evm_pkg::EVM_ST_EVAL;
        end
      end
      evm_pkg::EVM_ST_EVAL: begin
        next_state = evm_pkg::EVM_ST_IDLE;
      end
      default: begin
        next_state = evm_pkg::EVM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= evm_pkg::EVM_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_conv_start <= 1'b0;
      from_single <= 1'b0;
    end else begin
      o_conv_start <= launch_single || launch_bg;
      if (launch_single || launch_bg) begin
        from_single <= launch_single;
      end
    end
  end

  // Done strobes outside a conversion are ignored, so a stray pulse from
  // the converter cannot disturb the held sample.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sample <= 8'h00;
    end else if (state == evm_pkg::EVM_ST_CONV && i_conv.done) begin
      sample <= i_conv.data;
    end
  end

  always_comb begin
    big_change = abs_diff(sample, reference) >
                 {{(8 - `EVM_DELTA_W){1'b0}}, voltage_change_delta};
    single_done = (state == evm_pkg::EVM_ST_EVAL) && from_single;
    change_hit = (state == evm_pkg::EVM_ST_EVAL) && !from_single &&
                 big_change;
  end

  // New reference.
  // The reference starts at zero, so software should run one single
  // conversion before it enables the background schedule.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_voltage_result <= `EVM_RST_RESULT;
      reference <= `EVM_RST_RESULT;
    end else if (single_done || change_hit) begin
      ext_voltage_result <= sample;
      reference <= sample;
    end
  end

  // No pending bit.
  // The pulse rises on the same edge that loads the result, so the
  // interrupt service always finds the new value.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_adc_irq <= 1'b0;
    end else begin
      o_adc_irq <= single_done || change_hit;
    end
  end

  // Self-clearing start.
  // The clear happens in the evaluation state and is skipped when software
  // writes the register in the same cycle, so it cannot swallow a new request.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      adc_start_control <= `EVM_RST_START;
    end else begin
      if (sfr_write(i_sfr, `EVM_ADDR_START)) begin
        adc_start_control <= i_sfr.wdata;
      end
      if (single_done && !sfr_write(i_sfr, `EVM_ADDR_START)) begin
        adc_start_control[`EVM_BIT_SINGLE_GO] <= 1'b0;
      end
    end
  end

  // Change flag.
  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      power_event_flags <= `EVM_RST_FLAGS;
    end else begin
      if (sfr_write(i_sfr, `EVM_ADDR_FLAGS)) begin
        power_event_flags <= i_sfr.wdata;
      end
      if (change_hit) begin
        power_event_flags[`EVM_BIT_VCHG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      power_event_enable <= `EVM_RST_ENABLE;
      change_delta_config <= `EVM_RST_DELTA;
      background_interval_config <= `EVM_RST_INTERVAL;
    end else begin
      if (sfr_write(i_sfr, `EVM_ADDR_ENABLE)) begin
        power_event_enable <= i_sfr.wdata;
      end
      if (sfr_write(i_sfr, `EVM_ADDR_DELTA)) begin
        change_delta_config <= i_sfr.wdata;
      end
      if (sfr_write(i_sfr, `EVM_ADDR_INTERVAL)) begin
        background_interval_config <= i_sfr.wdata;
      end
    end
  end

  // Power interrupt gate.
  // The interrupt is a level that follows the flag, so it stays up until
  // software clears the flag or the enable.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_psm_irq <= 1'b0;
    end else begin
      o_psm_irq <= power_event_flags[`EVM_BIT_VCHG] &&
                   power_event_enable[`EVM_BIT_VCHG_EN];
    end
  end

  // Reads return one cycle after the strobe; unmapped addresses read zero
  // with the hit flag low so a shared register space can merge answers.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sfr_rdata <= `EVM_RDATA_NONE;
      o_sfr_hit <= 1'b0;
    end else begin
      o_sfr_hit <= 1'b0;
      o_sfr_rdata <= `EVM_RDATA_NONE;
      if (i_sfr.rd) begin
        o_sfr_hit <= 1'b1;
        unique case (i_sfr.addr)
          `EVM_ADDR_START: o_sfr_rdata <= adc_start_control;
          `EVM_ADDR_ENABLE: o_sfr_rdata <= power_event_enable;
          `EVM_ADDR_RESULT: o_sfr_rdata <= ext_voltage_result;
          `EVM_ADDR_DELTA: o_sfr_rdata <= change_delta_config;
          `EVM_ADDR_FLAGS: o_sfr_rdata <= power_event_flags;
          `EVM_ADDR_INTERVAL: o_sfr_rdata <= background_interval_config;
          default: o_sfr_hit <= 1'b0;
        endcase
      end
    end
  end

endmodule // evm_ctrl

// ### testbench/evm_ctrl_chk.sv
// Port assertions for the external voltage monitor control.
`timescale 1ns/1ps
module evm_ctrl_chk #(
  parameter int BASE_CYCLES = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire evm_pkg::evm_sfr_req_t i_sfr,
  input wire evm_pkg::evm_pwr_t i_power_mode,
  input wire evm_pkg::evm_conv_t i_conv,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  input wire logic o_conv_start,
  input wire logic o_adc_irq,
  input wire logic o_psm_irq
);
  logic busy;
  logic sgl;
  logic en;
  logic [1:0] dd;
  logic go;
  logic map;
  assign go = i_sfr.wr && i_sfr.addr == 8'hD8 && i_sfr.wdata[2];
  assign map = i_sfr.addr inside {8'hD8, 8'hEC, 8'hEF, 8'hF3, 8'hF8, 8'hF9};
  // Busy lasts until the result of the running conversion is judged.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy <= 1'b0;
      dd <= 2'b00;
    end else begin
      dd <= {dd[0], i_conv.done & busy};
      if (o_conv_start) begin
        busy <= 1'b1;
      end else if (dd[1]) begin
        busy <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sgl <= 1'b0;
    end else if (go) begin
      sgl <= 1'b1;
    end else if (o_adc_irq) begin
      sgl <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      en <= 1'b0;
    end else if (i_sfr.wr && i_sfr.addr == 8'hEC) begin
      en <= i_sfr.wdata[3];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_mapped_read_hit: assert property (i_sfr.rd && map |=> o_sfr_hit)
    else $error("Mapped read gave no hit.");
  a_unmapped_read_zero: assert property (
    i_sfr.rd && !map |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
    else $error("Unmapped read answered.");
  a_start_one_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("Start pulse too long.");
  a_single_start_lat: assert property (
    go && i_power_mode == evm_pkg::EVM_PWR_FULL && !busy && !sgl
    |=> ##1 o_conv_start)
    else $error("Single start not launched.");
  a_single_done_irq: assert property (
    i_conv.done && busy && sgl |-> ##2 o_adc_irq)
    else $error("Single completion gave no interrupt.");
  a_irq_from_done: assert property (o_adc_irq |-> $past(i_conv.done, 2))
    else $error("Interrupt without a conversion result.");
  a_battery_no_bg: assert property (
    !$past(sgl) && $past(i_power_mode) == evm_pkg::EVM_PWR_BATTERY
    |-> !o_conv_start)
    else $error("Background start in battery mode.");
  a_psm_gated: assert property (!$past(en) |-> !o_psm_irq)
    else $error("Power interrupt while disabled.");
  c_single_irq: cover property (sgl && o_adc_irq);
  c_psm_irq: cover property (o_psm_irq);
  c_sleep_bg: cover property (
    i_power_mode == evm_pkg::EVM_PWR_SLEEP && o_conv_start);
endmodule // evm_ctrl_chk

bind evm_ctrl evm_ctrl_chk #(.BASE_CYCLES(BASE_CYCLES)) evm_ctrl_chk_i (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_sfr(i_sfr),
  .i_power_mode(i_power_mode),
  .i_conv(i_conv),
  .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_hit(o_sfr_hit),
  .o_conv_start(o_conv_start),
  .o_adc_irq(o_adc_irq),
  .o_psm_irq(o_psm_irq)
);

// ### testbench/evm_ctrl_tb.sv
// Self-checking bench for the external voltage monitor control.
`timescale 1ns/1ps
module evm_ctrl_tb;
  logic i_clk_sys;
  logic i_rst;
  evm_pkg::evm_sfr_req_t i_sfr;
  evm_pkg::evm_pwr_t i_power_mode;
  evm_pkg::evm_conv_t i_conv;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_hit;
  logic o_conv_start;
  logic o_adc_irq;
  logic o_psm_irq;
  int n_errors = 0;
  int num_checks = 0;
  int starts = 0;
  int taken = 0;
  localparam logic [7:0] ADDRS [6] = '{8'hD8, 8'hEC, 8'hEF, 8'hF3,
                                       8'hF8, 8'hF9};

  evm_ctrl #(.BASE_CYCLES(16)) evm_ctrl_i (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_sfr(i_sfr),
    .i_power_mode(i_power_mode),
    .i_conv(i_conv),
    .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit),
    .o_conv_start(o_conv_start),
    .o_adc_irq(o_adc_irq),
    .o_psm_irq(o_psm_irq)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // Background starts may pulse during register reads, so they are counted.
  always @(posedge i_clk_sys) begin
    if (o_conv_start === 1'b1) starts++;
  end

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
    i_sfr.wr = 1'b0;
    step(1);
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e,
                        input logic h);
    i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    i_sfr.rd = 1'b0;
    check(o_sfr_rdata, e);
    check({7'h00, o_sfr_hit}, {7'h00, h});
    step(1);
  endtask

  task automatic convert(input logic [7:0] d, input logic irq);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    while (starts <= taken && k < 300) begin
      step(1);
      k++;
    end
    taken++;
    check({7'h00, k < 300}, 8'h01);
    step(2);
    i_conv = '{done: 1'b1, data: d};
    step(1);
    i_conv.done = 1'b0;
    repeat (4) begin
      seen |= o_adc_irq;
      step(1);
    end
    check({7'h00, seen}, {7'h00, irq});
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    stop_test();
  end

  initial begin
    i_rst = 1'b1;
    i_sfr = '0;
    i_conv = '0;
    i_power_mode = evm_pkg::EVM_PWR_FULL;
    step(4);
    i_rst = 1'b0;
    foreach (ADDRS[i]) sfr_rd(ADDRS[i], 8'h00, 1'b1);
    sfr_rd(8'h00, 8'h00, 1'b0);
    check(8'(starts), 8'h00);
    sfr_wr(8'hEF, 8'hAA);
    sfr_rd(8'hEF, 8'h00, 1'b1);
    sfr_wr(8'hD8, 8'h04);
    convert(8'h40, 1'b1);
    sfr_rd(8'hEF, 8'h40, 1'b1);
    sfr_rd(8'hD8, 8'h00, 1'b1);
    i_power_mode = evm_pkg::EVM_PWR_SLEEP;
    sfr_wr(8'hD8, 8'h04);
    step(30);
    check(8'(starts - taken), 8'h00);
    i_power_mode = evm_pkg::EVM_PWR_BATTERY;
    convert(8'h10, 1'b1);
    sfr_rd(8'hEF, 8'h10, 1'b1);
    sfr_wr(8'hF3, 8'h03);
    sfr_wr(8'hEC, 8'h08);
    sfr_rd(8'hF3, 8'h03, 1'b1);
    sfr_wr(8'hF9, 8'h10);
    step(60);
    check(8'(starts - taken), 8'h00);
    i_power_mode = evm_pkg::EVM_PWR_FULL;
    convert(8'h13, 1'b0);
    sfr_rd(8'hEF, 8'h10, 1'b1);
    sfr_rd(8'hF8, 8'h00, 1'b1);
    convert(8'h0C, 1'b1);
    sfr_rd(8'hEF, 8'h0C, 1'b1);
    sfr_rd(8'hF8, 8'h08, 1'b1);
    check({7'h00, o_psm_irq}, 8'h01);
    sfr_wr(8'hEC, 8'h00);
    check({7'h00, o_psm_irq}, 8'h00);
    i_power_mode = evm_pkg::EVM_PWR_SLEEP;
    convert(8'h10, 1'b1);
    sfr_rd(8'hEF, 8'h10, 1'b1);
    stop_test();
  end
endmodule // evm_ctrl_tb
